// ===== gcr_pkg.sv
// package: constants and types for the global configuration register page
//
// Notes on behaviour
// - five registers decoded in the global page
// - bits 15,14 pair channels 2-3 and 0-1
// - bit 9 reloads calibration, reads zero afterwards
// - bit 8 set turns spreading off
// - bit 0 staggers fixed-frequency channels only
// - two-bit state per channel, reset 0x0055
// - state 00: driver off, diagnostics masked
// - state 01: high impedance, diagnostics per config
// - states 10 pwm, 11 full-on, diagnostics masked
// - bits 6:5 give reset count two^(N+1)
// - bits 4:2 give gap 504us times two^N
// - bit 1 enables, bit 0 disables latch
// - pre-driver enables at bits 11,8,5,2
// - two-bit drain-source threshold per pre-driver
// - identification read-only, version 5:3, subversion 2:0
// - frame carries 8-bit address, 16-bit data
// - global page is seventh page at 0xc0
package gcr_pkg;

   ////////////////////////////////////////////////////////////////////////
   // addressing
   localparam logic [2:0] page_global    = 3'h6;
   localparam logic [4:0] idx_service    = 5'h00;
   localparam logic [4:0] idx_drv_state  = 5'h01;
   localparam logic [4:0] idx_timeout    = 5'h02;
   localparam logic [4:0] idx_failsafe   = 5'h03;
   localparam logic [4:0] idx_ident      = 5'h1f;

   ////////////////////////////////////////////////////////////////////////
   // reset values and writable masks
   localparam logic [15:0] rst_service   = 16'h0000;
   localparam logic [15:0] rst_drv_state = 16'h0055;
   localparam logic [15:0] rst_timeout   = 16'h0028;
   localparam logic [15:0] rst_failsafe  = 16'h0000;
   localparam logic [15:0] msk_service   = 16'hc301;
   localparam logic [15:0] msk_drv_state = 16'h00ff;
   localparam logic [15:0] msk_timeout   = 16'h007f;
   localparam logic [15:0] msk_failsafe  = 16'h0fff;

   ////////////////////////////////////////////////////////////////////////
   // field positions
   localparam int pos_par23    = 15;
   localparam int pos_par01    = 14;
   localparam int pos_reload   = 9;
   localparam int pos_ss_off   = 8;
   localparam int pos_stagger  = 0;
   localparam int pos_nr_rst   = 5;
   localparam int pos_tmo_cfg  = 2;
   localparam int pos_latch_en = 1;
   localparam int pos_latch_ds = 0;
   localparam int pos_ver      = 3;

   ////////////////////////////////////////////////////////////////////////
   // timing
   localparam int clk_mhz         = 50;
   localparam int tmo_base_us     = 504;
   localparam int tmo_base_cycles = tmo_base_us * clk_mhz;

   ////////////////////////////////////////////////////////////////////////
   // types
   typedef enum logic [1:0] {
      gcr_drv_off   = 2'h0,
      gcr_drv_hiz   = 2'h1,
      gcr_drv_pwm   = 2'h2,
      gcr_drv_full  = 2'h3
   } gcr_drv_t;

   typedef enum logic [1:0] {
      gcr_rl_idle = 2'h0,
      gcr_rl_busy = 2'h1,
      gcr_rl_done = 2'h3
   } gcr_rl_t;

   typedef struct packed {
      logic        valid;
      logic        write;
      logic [7:0]  addr;
      logic [15:0] wdata;
   } gcr_req_t;

   typedef struct packed {
      logic [3:0] drv_on;
      logic [3:0] drv_full;
      logic [3:0] drv_hiz;
      logic [3:0] diag_mask;
   } gcr_chan_t;

   // all channels tristate with diagnostics masked while in reset
   localparam gcr_chan_t rst_chan = '{4'h0, 4'h0, 4'hf, 4'hf};

endpackage

// ===== gcr_reload.sv
// calibration reload sequencer
`timescale 1ns/100ps
`default_nettype none
module gcr_reload (
   // clock and reset
   input  wire logic clk,
   input  wire logic rst,
   // control
   input  wire logic start,
   input  wire logic nvm_done,
   output logic      nvm_req,
   output logic      busy
);
   gcr_pkg::gcr_rl_t st;
   gcr_pkg::gcr_rl_t next_st;

   always_comb begin
      next_st = st;
      case (st)
         gcr_pkg::gcr_rl_idle: if (start) next_st = gcr_pkg::gcr_rl_busy;
         gcr_pkg::gcr_rl_busy: if (nvm_done) next_st = gcr_pkg::gcr_rl_done;
         default:              next_st = start ? gcr_pkg::gcr_rl_busy
                                               : gcr_pkg::gcr_rl_idle;
      endcase
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         st      <= gcr_pkg::gcr_rl_idle;
         nvm_req <= 1'b0;
         busy    <= 1'b0;
      end else begin
         st      <= next_st;
         nvm_req <= (next_st == gcr_pkg::gcr_rl_busy);
         busy    <= (next_st == gcr_pkg::gcr_rl_busy);
      end
   end
endmodule
`default_nettype wire

// ===== gcr_timeout.sv
// serial link gap watchdog and reset counter
`timescale 1ns/100ps
`default_nettype none
module gcr_timeout (
   // clock and reset
   input  wire logic       clk,
   input  wire logic       rst,
   // settings
   input  wire logic [2:0] tmo_sel,
   input  wire logic [1:0] nr_sel,
   input  wire logic       latch_on,
   // events
   input  wire logic       frame_ok,
   output logic            tmo_pulse,
   output logic            force_rst
);
   logic [31:0] cnt;
   logic [31:0] next_cnt;
   logic [4:0]  ev;
   logic [4:0]  next_ev;
   logic [31:0] limit;
   logic [4:0]  ev_limit;
   logic        hit;

   always_comb begin
      limit    = 32'(gcr_pkg::tmo_base_cycles) << tmo_sel;
      ev_limit = 5'(5'h02 << nr_sel);
      hit      = (cnt >= limit);
      next_cnt = (frame_ok || hit) ? 32'h0 : cnt + 32'h1;
      next_ev  = ev;
      if (hit && ev != 5'h1f)
         next_ev = ev + 5'h01;
      if (!latch_on)
         next_ev = 5'h00;
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         cnt       <= 32'h0;
         ev        <= 5'h00;
         tmo_pulse <= 1'b0;
         force_rst <= 1'b0;
      end else begin
         cnt       <= next_cnt;
         ev        <= next_ev;
         tmo_pulse <= hit;
         force_rst <= latch_on && (next_ev >= ev_limit);
      end
   end
endmodule
`default_nettype wire

// ===== gcr_top.sv
// global configuration register page
`timescale 1ns/100ps
`default_nettype none
module gcr_top #(
   parameter logic [2:0] ver_code = 3'h0,   // arbitrary value
   parameter logic [2:0] sub_code = 3'h0    // arbitrary value
) (
   // clock and reset
   input  wire logic              clk,
   input  wire logic              rst,
   // register access from frame decoder
   input  wire gcr_pkg::gcr_req_t req,
   output logic [15:0]            rdata,
   output logic                   rvalid,
   output logic                   hit_page,
   // nonvolatile memory download
   input  wire logic              nvm_done,
   output logic                   nvm_req,
   // service controls
   output logic                   par_ch23,
   output logic                   par_ch01,
   output logic                   spread_off,
   output logic                   stagger_on,
   // channel drive
   output gcr_pkg::gcr_chan_t     chan,
   input  wire logic [3:0]        offdiag_cfg,
   input  wire logic [3:0]        fixed_freq,
   output logic [3:0]             stagger_ch,
   // fail-safe pre-drivers
   output logic [3:0]             failsafe_predriver_on,
   output logic [7:0]             vds_threshold,
   // link timeout
   input  wire logic              frame_ok,
   output logic                   timeout_flag,
   output logic                   timeout_reset
);

   ////////////////////////////////////////////////////////////////////////
   // registers
   logic [15:0] general_service_controls;
   logic [15:0] channel_driver_states;
   logic [15:0] link_timeout_settings;
   logic [15:0] failsafe_predriver_settings;
   logic [15:0] next_service;
   logic [15:0] next_drv;
   logic [15:0] next_tmo;
   logic [15:0] next_fs;
   logic [15:0] next_rdata;
   logic        next_hit;
   logic        wr;
   logic        rl_busy;
   logic        rl_start;
   logic        latch_on;
   logic        tmo_pulse;
   logic        force_rst;
   gcr_pkg::gcr_chan_t next_chan;
   logic [3:0]  next_stagger_ch;

   function automatic logic [15:0] merge(input logic [15:0] old_v,
                                         input logic [15:0] new_v,
                                         input logic [15:0] msk);
      merge = (old_v & ~msk) | (new_v & msk);
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // address decode and register update
   always_comb begin
      next_hit     = req.valid && (req.addr[7:5] == gcr_pkg::page_global);
      wr           = next_hit && req.write;
      next_service = general_service_controls;
      next_drv     = channel_driver_states;
      next_tmo     = link_timeout_settings;
      next_fs      = failsafe_predriver_settings;
      rl_start     = 1'b0;
      next_rdata   = 16'h0000;
      if (req.addr[4:0] == gcr_pkg::idx_service) begin
         if (wr) begin
            next_service = merge(general_service_controls,
                                 req.wdata, gcr_pkg::msk_service);
            rl_start = req.wdata[gcr_pkg::pos_reload] && !rl_busy;
         end
         next_rdata = general_service_controls;
      end else if (req.addr[4:0] == gcr_pkg::idx_drv_state) begin
         if (wr)
            next_drv = merge(channel_driver_states, req.wdata,
                             gcr_pkg::msk_drv_state);
         next_rdata = channel_driver_states;
      end else if (req.addr[4:0] == gcr_pkg::idx_timeout) begin
         if (wr)
            next_tmo = merge(link_timeout_settings, req.wdata,
                             gcr_pkg::msk_timeout);
         next_rdata = link_timeout_settings;
      end else if (req.addr[4:0] == gcr_pkg::idx_failsafe) begin
         if (wr)
            next_fs = merge(failsafe_predriver_settings, req.wdata,
                            gcr_pkg::msk_failsafe);
         next_rdata = failsafe_predriver_settings;
      end else if (req.addr[4:0] == gcr_pkg::idx_ident) begin
         next_rdata = 16'(ver_code) << gcr_pkg::pos_ver;
         next_rdata = next_rdata | 16'(sub_code);
      end
      // reload bit reflects the download in progress
      next_service[gcr_pkg::pos_reload] = rl_start || rl_busy;
      if (!next_hit)
         next_rdata = 16'h0000;
   end

   ////////////////////////////////////////////////////////////////////////
   // channel state decode
   always_comb begin
      next_chan = '0;
      for (int i = 0; i < 4; i++) begin
         case (gcr_pkg::gcr_drv_t'(next_drv[2*i +: 2]))
            gcr_pkg::gcr_drv_off: begin
               next_chan.diag_mask[i] = 1'b1;
            end
            gcr_pkg::gcr_drv_hiz: begin
               next_chan.drv_hiz[i]   = 1'b1;
               next_chan.diag_mask[i] = !offdiag_cfg[i];
            end
            gcr_pkg::gcr_drv_pwm: begin
               next_chan.drv_on[i]    = 1'b1;
               next_chan.diag_mask[i] = 1'b1;
            end
            default: begin
               next_chan.drv_on[i]    = 1'b1;
               next_chan.drv_full[i]  = 1'b1;
               next_chan.diag_mask[i] = 1'b1;
            end
         endcase
      end
      next_stagger_ch = fixed_freq &
                        {4{next_service[gcr_pkg::pos_stagger]}};
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         general_service_controls    <= gcr_pkg::rst_service;
         channel_driver_states       <= gcr_pkg::rst_drv_state;
         link_timeout_settings       <= gcr_pkg::rst_timeout;
         failsafe_predriver_settings <= gcr_pkg::rst_failsafe;
         rdata                       <= 16'h0000;
         rvalid                      <= 1'b0;
         hit_page                    <= 1'b0;
         chan                        <= gcr_pkg::rst_chan;
         stagger_ch                  <= 4'h0;
      end else begin
         general_service_controls    <= next_service;
         channel_driver_states       <= next_drv;
         link_timeout_settings       <= next_tmo;
         failsafe_predriver_settings <= next_fs;
         rdata                       <= next_rdata;
         rvalid                      <= req.valid && !req.write;
         hit_page                    <= next_hit;
         chan                        <= next_chan;
         stagger_ch                  <= next_stagger_ch;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // registered field outputs
   always_ff @(posedge clk) begin
      if (rst) begin
         par_ch23              <= 1'b0;
         par_ch01              <= 1'b0;
         spread_off            <= 1'b0;
         stagger_on            <= 1'b0;
         failsafe_predriver_on <= 4'h0;
         vds_threshold         <= 8'h00;
         timeout_flag          <= 1'b0;
         timeout_reset         <= 1'b0;
      end else begin
         par_ch23   <= next_service[gcr_pkg::pos_par23];
         par_ch01   <= next_service[gcr_pkg::pos_par01];
         spread_off <= next_service[gcr_pkg::pos_ss_off];
         stagger_on <= next_service[gcr_pkg::pos_stagger];
         failsafe_predriver_on <= {next_fs[11], next_fs[8],
                                   next_fs[5], next_fs[2]};
         vds_threshold <= {next_fs[10:9], next_fs[7:6],
                           next_fs[4:3], next_fs[1:0]};
         timeout_flag  <= tmo_pulse;
         timeout_reset <= force_rst;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // submodules
   assign latch_on = link_timeout_settings[gcr_pkg::pos_latch_en] &&
                     !link_timeout_settings[gcr_pkg::pos_latch_ds];

   gcr_reload u_reload (
      .clk      (clk),
      .rst      (rst),
      .start    (rl_start),
      .nvm_done (nvm_done),
      .nvm_req  (nvm_req),
      .busy     (rl_busy)
   );

   gcr_timeout u_timeout (
      .clk       (clk),
      .rst       (rst),
      .tmo_sel   (link_timeout_settings[gcr_pkg::pos_tmo_cfg +: 3]),
      .nr_sel    (link_timeout_settings[gcr_pkg::pos_nr_rst +: 2]),
      .latch_on  (latch_on),
      .frame_ok  (frame_ok),
      .tmo_pulse (tmo_pulse),
      .force_rst (force_rst)
   );

endmodule
`default_nettype wire

// ===== gcr_props.sv
// checker for the global configuration register page
`timescale 1ns/100ps
`default_nettype none
module gcr_props (
   // clock and reset
   input wire logic              clk,
   input wire logic              rst,
   // register port
   input wire gcr_pkg::gcr_req_t req,
   input wire logic [15:0]       rdata,
   input wire logic              rvalid,
   input wire logic              hit_page,
   // download
   input wire logic              nvm_done,
   input wire logic              nvm_req,
   // outputs, with the offdiag_cfg, fixed_freq and frame_ok inputs
   input wire logic              par_ch23,
   input wire logic              par_ch01,
   input wire logic              spread_off,
   input wire logic              stagger_on,
   input wire gcr_pkg::gcr_chan_t chan,
   input wire logic [3:0]        offdiag_cfg,
   input wire logic [3:0]        fixed_freq,
   input wire logic [3:0]        stagger_ch,
   input wire logic [3:0]        failsafe_predriver_on,
   input wire logic [7:0]        vds_threshold,
   input wire logic              frame_ok,
   input wire logic              timeout_flag,
   input wire logic              timeout_reset
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);
   logic        wr;
   logic [15:0] w;
   assign wr = req.valid && req.write;
   assign w  = req.wdata;
   ////////////////////////////////////////////////////////////////////////
   property p_hit;
      req.valid |=> hit_page == $past(req.addr[7:5] == 3'h6);
   endproperty
   a_hit: assert property (p_hit) else $error("page hit wrong");
   property p_miss;
      req.valid && req.addr[7:5] != 3'h6 |=> rdata == 16'h0000;
   endproperty
   a_miss: assert property (p_miss) else $error("foreign read");
   property p_id;
      req.valid && !req.write && req.addr == 8'hdf
         |=> rvalid && rdata[15:6] == 10'h000;
   endproperty
   a_id: assert property (p_id) else $error("id bits wrong");
   property p_unused;
      req.valid && !req.write && req.addr == 8'hc0
         |=> (rdata & 16'h3cfe) == 16'h0000;
   endproperty
   a_unused: assert property (p_unused) else $error("unused set");
   property p_svc;
      wr && req.addr == 8'hc0 |=> {par_ch23, par_ch01, spread_off,
         stagger_on} == $past({w[15], w[14], w[8], w[0]});
   endproperty
   a_svc: assert property (p_svc) else $error("service bits");
   property p_fs;
      wr && req.addr == 8'hc3 |=> {failsafe_predriver_on, vds_threshold}
         == $past({w[11], w[8], w[5], w[2], w[10:9], w[7:6], w[4:3],
         w[1:0]});
   endproperty
   a_fs: assert property (p_fs) else $error("failsafe map");
   property p_stag;
      $stable(fixed_freq) |-> stagger_ch == (fixed_freq & {4{stagger_on}});
   endproperty
   a_stag: assert property (p_stag) else $error("stagger");
   property p_mask;
      ((chan.drv_on | ~chan.drv_hiz) & ~chan.diag_mask) == 4'h0;
   endproperty
   a_mask: assert property (p_mask) else $error("diag mask");
   property p_hiz;
      $stable(offdiag_cfg) |-> (chan.drv_hiz & chan.drv_on) == 4'h0
         && (chan.drv_hiz & (chan.diag_mask ^ ~offdiag_cfg)) == 4'h0;
   endproperty
   a_hiz: assert property (p_hiz) else $error("tristate");
   property p_rl;
      wr && req.addr == 8'hc0 && w[9] && !nvm_req |=> nvm_req;
   endproperty
   a_rl: assert property (p_rl) else $error("no reload");
   property p_rl_end;
      nvm_done && nvm_req |-> ##[1:3] !nvm_req;
   endproperty
   a_rl_end: assert property (p_rl_end) else $error("reload stuck");
   property p_tmo;
      timeout_flag |=> !timeout_flag;
   endproperty
   a_tmo: assert property (p_tmo) else $error("flag long");
   c_rl: cover property (nvm_done && nvm_req);
   c_tmo: cover property (timeout_flag);
   c_rst: cover property ($rose(timeout_reset));
endmodule
bind gcr_top gcr_props u_props (.clk(clk), .rst(rst), .req(req),
   .rdata(rdata), .rvalid(rvalid), .hit_page(hit_page),
   .nvm_done(nvm_done), .nvm_req(nvm_req), .par_ch23(par_ch23),
   .par_ch01(par_ch01), .spread_off(spread_off), .stagger_on(stagger_on),
   .chan(chan), .offdiag_cfg(offdiag_cfg), .fixed_freq(fixed_freq),
   .stagger_ch(stagger_ch), .failsafe_predriver_on(failsafe_predriver_on),
   .vds_threshold(vds_threshold), .frame_ok(frame_ok),
   .timeout_flag(timeout_flag), .timeout_reset(timeout_reset));
`default_nettype wire

// ===== gcr_nvm_model.sv
// calibration memory model answering download requests
`timescale 1ns/100ps
`default_nettype none
module gcr_nvm_model (
   // clock and reset
   input wire logic       clk,
   input wire logic       rst,
   // download handshake
   input wire logic       nvm_req,
   input wire logic [3:0] lag,
   output logic           nvm_done
);
   logic [4:0] cnt;
   // one done pulse per request, lag plus five cycles after it rises
   always_ff @(posedge clk) begin
      if (rst || !nvm_req) begin
         cnt      <= 5'h00;
         nvm_done <= 1'b0;
      end else begin
         nvm_done <= (cnt == {1'b0, lag} + 5'h04);
         if (cnt != 5'h1f) cnt <= cnt + 5'h01;
      end
   end
endmodule
`default_nettype wire

// ===== gcr_top_test.sv
// self-checking bench for the global configuration register page
`timescale 1ns/100ps
`default_nettype none
module gcr_top_test;
   localparam logic [2:0] ver = 3'h5; // arbitrary
   localparam logic [2:0] sub = 3'h2; // arbitrary
   logic clk = 1'b0, rst = 1'b1, nvm_done, nvm_req, rvalid, hit_page;
   logic par_ch23, par_ch01, spread_off, stagger_on, frame_ok = 1'b0;
   logic timeout_flag, timeout_reset;
   gcr_pkg::gcr_req_t  req = '0;
   gcr_pkg::gcr_chan_t chan;
   logic [15:0] rdata, w, e, q;
   logic [1:0]  qv;
   logic [7:0]  s, vds_threshold;
   logic [3:0]  offdiag_cfg = 4'h0, fixed_freq = 4'h0, lag = 4'h0;
   logic [3:0]  stagger_ch, failsafe_predriver_on;
   logic [7:0]  ra [5] = '{8'hc0, 8'hc1, 8'hc2, 8'hc3, 8'hdf};
   logic [15:0] rv [5] = '{16'h0000, 16'h0055, 16'h0028, 16'h0000,
                           {10'h000, ver, sub}};
   logic [15:0] mk [5] = '{16'hc101, 16'h00ff, 16'h007f, 16'h0fff, 16'h0};
   int err_count = 0, n_tests = 0, i, j, n;
   always #10 clk = ~clk;
   gcr_top #(.ver_code(ver), .sub_code(sub)) DUT (.clk(clk), .rst(rst),
      .req(req), .rdata(rdata), .rvalid(rvalid), .hit_page(hit_page),
      .nvm_done(nvm_done), .nvm_req(nvm_req), .par_ch23(par_ch23),
      .par_ch01(par_ch01), .spread_off(spread_off), .stagger_on(stagger_on),
      .chan(chan), .offdiag_cfg(offdiag_cfg), .fixed_freq(fixed_freq),
      .stagger_ch(stagger_ch), .failsafe_predriver_on(failsafe_predriver_on),
      .vds_threshold(vds_threshold), .frame_ok(frame_ok),
      .timeout_flag(timeout_flag), .timeout_reset(timeout_reset));
   gcr_nvm_model u_nvm (.clk(clk), .rst(rst), .nvm_req(nvm_req),
      .lag(lag), .nvm_done(nvm_done));
   ////////////////////////////////////////////////////////////////////////
   task automatic results;
      $display("tests %0d errors %0d", n_tests, err_count);
      if (err_count == 0 && n_tests > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      n_tests++;
      if (got !== exp) begin
         err_count++;
         $display("[ERR] %0t got %h exp %h", $time, got, exp);
      end
   endtask
   // one frame: 8-bit address, 16-bit word, answer sampled when settled
   task automatic acc(input logic wr, input logic [7:0] a,
                      input logic [15:0] d);
      @(negedge clk) req = '{1'b1, wr, a, d};
      @(negedge clk) req.valid = 1'b0;
      q  = rdata;
      qv = {rvalid, hit_page};
      @(negedge clk);
   endtask
   task automatic wflag(output int cnt);
      cnt = 0;
      while (timeout_flag !== 1'b1 && cnt < 30000) begin
         @(negedge clk);
         cnt++;
      end
      if (cnt >= 30000) begin
         err_count++;
         results();
      end
   endtask
   function automatic logic [15:0] chan_exp(input logic [7:0] st,
                                            input logic [3:0] cfg);
      logic [15:0] r;
      r = 16'h0000;
      for (int k = 0; k < 4; k++) begin
         r[12+k] = st[2*k+1];
         r[8+k]  = st[2*k+:2] == 2'h3;
         r[4+k]  = st[2*k+:2] == 2'h1;
         r[k]    = st[2*k+:2] == 2'h1 ? ~cfg[k] : 1'b1;
      end
      return r;
   endfunction
   ////////////////////////////////////////////////////////////////////////
   initial begin
      void'($urandom(32'h0fc4));
      repeat (12) @(negedge clk);
      rst = 1'b0;
      for (i = 0; i < 5; i++) begin
         acc(1'b0, ra[i], 16'h0000);
         chk(q & (i == 4 ? 16'hffbf : 16'hffff), rv[i]);
         chk(16'(qv), 16'h0003);
      end
      for (i = 0; i < 24; i++) begin
         j = $urandom % 5;
         w = 16'($urandom) & ~16'h0200;
         acc(1'b1, ra[j], w);
         acc(1'b0, ra[j], 16'h0000);
         e = (w & mk[j]) | (j == 4 ? rv[4] : 16'h0000);
         chk(q & (j == 4 ? 16'hffbf : 16'hffff), e);
      end
      acc(1'b1, 8'hc4, 16'hffff);
      acc(1'b0, 8'hc4, 16'h0000);
      chk(q, 16'h0000);
      fixed_freq = 4'(($urandom));
      acc(1'b1, 8'hc0, 16'hc101);
      acc(1'b1, 8'he0, 16'h0000);
      chk(16'(qv[0]), 16'h0000);
      acc(1'b0, 8'hc0, 16'h0000);
      chk(q, 16'hc101);
      chk(16'({par_ch23, par_ch01, spread_off, stagger_on}), 16'hf);
      chk(16'(stagger_ch), 16'(fixed_freq));
      acc(1'b1, 8'hc0, 16'h0100);
      chk(16'({spread_off, stagger_ch}), 16'h0010);
      for (i = 0; i < 8; i++) begin
         s = 8'($urandom);
         if (i < 4) s = {4{i[1:0]}};
         offdiag_cfg = 4'($urandom);
         acc(1'b1, 8'hc1, {8'h00, s});
         @(negedge clk);
         chk(chan, chan_exp(s, offdiag_cfg));
      end
      for (i = 0; i < 4; i++) begin
         w = 16'($urandom);
         acc(1'b1, 8'hc3, w);
         @(negedge clk);
         chk(16'({failsafe_predriver_on, vds_threshold}), 16'({w[11], w[8],
             w[5], w[2], w[10:9], w[7:6], w[4:3], w[1:0]}));
      end
      for (i = 0; i < 2; i++) begin
         lag = i[0] ? 4'hf : 4'h0;
         acc(1'b1, 8'hc0, 16'h0200);
         acc(1'b0, 8'hc0, 16'h0000);
         chk(q, 16'h0200);
         if (i == 1) acc(1'b1, 8'hc0, 16'h0000);
         chk(16'(nvm_req), 16'h0001);
         for (n = 0; nvm_req === 1'b1 && n < 40; n++) @(negedge clk);
         if (n >= 40) begin
            err_count++;
            results();
         end
         acc(1'b0, 8'hc0, 16'h0000);
         chk(q, 16'h0000);
      end
      acc(1'b1, 8'hc2, 16'h0002);
      @(negedge clk) frame_ok = 1'b1;
      @(negedge clk) frame_ok = 1'b0;
      wflag(n);
      chk(16'(n >= 25197 && n <= 25206), 16'h0001);
      @(negedge clk);
      chk(16'(timeout_reset), 16'h0000);
      wflag(n);
      repeat (4) @(negedge clk);
      chk(16'(timeout_reset), 16'h0001);
      acc(1'b1, 8'hc2, 16'h0003);
      repeat (3) @(negedge clk);
      chk(16'(timeout_reset), 16'h0000);
      results();
   end
endmodule
`default_nettype wire
